// [rtl/sfr_defs.svh]
// Purpose: Shared constants of the serial flash read path
// Assumes: Core clock of 250 MHz
// Notes:   Included by its bare name
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

// Opcodes
`define SFR_OP_LEGACY_READ   8'hE8
`define SFR_OP_FAST_READ     8'h0B
`define SFR_OP_SLOW_READ     8'h03
`define SFR_OP_PAGE_READ     8'hD2

// Frame layout, in bits
`define SFR_OPCODE_BITS      6'h08
`define SFR_ADDR_BITS        6'h18
`define SFR_DUMMY_LONG_BITS  6'h20
`define SFR_DUMMY_SHORT_BITS 6'h08

// Address fields
`define SFR_PAGE_W           9
`define SFR_OFFSET_W         9
`define SFR_LAST_PAGE        9'h1FF
`define SFR_LAST_OFFSET_264  9'h107
`define SFR_LAST_OFFSET_256  9'h0FF

// Timing
`define SFR_CLK_PERIOD_NS        4
`define SFR_SCK_HALF_NS          80
`define SFR_SCK_HALF_CYC         ((`SFR_SCK_HALF_NS + `SFR_CLK_PERIOD_NS - 1) / `SFR_CLK_PERIOD_NS)
`define SFR_FAST_READ_CLOCK_LIMIT_MHZ 66
`define SFR_SLOW_READ_CLOCK_LIMIT_MHZ 33
`define SFR_CLK_MHZ              (1000 / `SFR_CLK_PERIOD_NS)
`define SFR_FAST_HALF_MIN_CYC    ((`SFR_CLK_MHZ + 2 * `SFR_FAST_READ_CLOCK_LIMIT_MHZ - 1) / \
                                  (2 * `SFR_FAST_READ_CLOCK_LIMIT_MHZ))
`define SFR_SLOW_HALF_MIN_CYC    ((`SFR_CLK_MHZ + 2 * `SFR_SLOW_READ_CLOCK_LIMIT_MHZ - 1) / \
                                  (2 * `SFR_SLOW_READ_CLOCK_LIMIT_MHZ))

// Data buffer
`define SFR_FIFO_WIDTH       8
`define SFR_FIFO_DEPTH       4

`endif

// [rtl/sfr_pkg.sv]
// Purpose: Types and shared decode of the serial flash read path
// Assumes: sfr_defs.svh on the include path
// Notes:   No constants of its own; numbers live in the header
`default_nettype none
`include "sfr_defs.svh"

package sfr_pkg;

  typedef enum logic [2:0] {
    SFR_PH_IDLE,
    SFR_PH_CMD,
    SFR_PH_ADDR,
    SFR_PH_DUMMY,
    SFR_PH_DATA,
    SFR_PH_IGNORE
  } sfr_dev_phase_t;

  typedef enum logic [1:0] {
    SFR_HS_IDLE,
    SFR_HS_SHIFT,
    SFR_HS_DESEL
  } sfr_host_state_t;

  // Dummy bits that follow the address, per opcode
  function automatic logic [5:0] sfr_dummy_bits(input logic [7:0] op);
    unique case (op)
      `SFR_OP_LEGACY_READ,
      `SFR_OP_PAGE_READ:  sfr_dummy_bits = `SFR_DUMMY_LONG_BITS;
      `SFR_OP_FAST_READ:  sfr_dummy_bits = `SFR_DUMMY_SHORT_BITS;
      default:            sfr_dummy_bits = 6'h00;
    endcase
  endfunction : sfr_dummy_bits

  function automatic logic sfr_is_read(input logic [7:0] op);
    sfr_is_read = (op == `SFR_OP_LEGACY_READ) || (op == `SFR_OP_FAST_READ) ||
                  (op == `SFR_OP_SLOW_READ) || (op == `SFR_OP_PAGE_READ);
  endfunction : sfr_is_read

endpackage : sfr_pkg
`default_nettype wire

// [rtl/sfr_link_if.sv]
// Purpose: Four-wire serial link plus reset pin between host and flash
// Assumes: Both ends on the same core clock, link clock sampled as data
// Notes:   Serial output idles high when nobody drives it
`timescale 1ns/1ps
`default_nettype none

interface sfr_link_if;
  logic cs_b;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic reset_b;
  logic so_line;

  // Resolved serial output as seen by the host
  assign so_line = so_oe ? so : 1'b1;

  modport device (
    input  cs_b,
    input  sck,
    input  si,
    input  reset_b,
    output so,
    output so_oe
  );

  modport host (
    output cs_b,
    output sck,
    output si,
    output reset_b,
    input  so_line
  );
endinterface : sfr_link_if
`default_nettype wire

// [rtl/sfr_fifo.sv]
// Purpose: Small synchronous FIFO between array fetch and serializer
// Assumes: Single clock, synchronous active-low reset
// Notes:   Flush drops all entries in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"

module sfr_fifo #(
  parameter int WIDTH = `SFR_FIFO_WIDTH,
  parameter int DEPTH = `SFR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff < (PW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + PW'(1));
  endfunction : wrap_inc

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || flush_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wrap_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= wrap_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= (PW+1)'(count_ff + (PW+1)'(1));
      end else if (pop && !push) begin
        count_ff <= (PW+1)'(count_ff - (PW+1)'(1));
      end
    end
  end
endmodule : sfr_fifo
`default_nettype wire

// [rtl/sfr_device.sv]
// Purpose: Flash end of the serial link: command decode and array read stream
// Assumes: Link pins sampled on clk_i; array read port answers one cycle after mem_rd_o
// Notes:   Buffer and program commands are not decoded; they are ignored until deselect
//
// Functional notes
// - Frame opens on select low, opcode, address
// - All fields travel most significant bit first
// - 264 mode: 9-bit page, 9-bit offset
// - 256 mode: upper 9 page, low 8 byte
// - E8H: address then four dummy bytes
// - 0BH: address then one dummy byte
// - 03H: address, data with no dummy
// - D2H: four dummy bytes, addressed page byte
// - Address counter advances, data stream unbroken
// - Page end continues into next page
// - Array end wraps to first page
// - Host keeps select low whole command
// - Select rising ends read, output released
// - Reads never alter the data buffer
// - Works in clock modes 0 and 3
// - Sample on rising, drive on falling
// - Reset pin low forces idle, holds
// - Page read wraps within same page
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"

module sfr_device (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Serial link
  sfr_link_if.device                    link,
  // Page size select, high for 256-byte pages
  input  wire logic                     page_256_i,
  // Array read port
  output logic      [`SFR_PAGE_W-1:0]   mem_page_o,
  output logic      [`SFR_OFFSET_W-1:0] mem_offset_o,
  output logic                          mem_rd_o,
  input  wire logic [7:0]               mem_data_i,
  // Status
  output logic                          busy_o
);
  localparam int PIN_N = 4;

  // Two-flop synchronisers for cs_b, sck, si, reset_b
  logic [PIN_N-1:0] meta_ff;
  logic [PIN_N-1:0] sync_ff;
  logic [PIN_N-1:0] pins;
  logic             sck_d_ff;
  logic             cs_d_ff;

  assign pins = {link.reset_b, link.si, link.sck, link.cs_b};

  generate
    for (genvar g = 0; g < PIN_N; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          meta_ff[g] <= 1'b1;
          sync_ff[g] <= 1'b1;
        end else begin
          meta_ff[g] <= pins[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  logic cs_b_s;
  logic sck_s;
  logic si_s;
  logic reset_b_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic abort;

  assign cs_b_s    = sync_ff[0];
  assign sck_s     = sync_ff[1];
  assign si_s      = sync_ff[2];
  assign reset_b_s = sync_ff[3];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sck_d_ff <= 1'b0;
      cs_d_ff  <= 1'b1;
    end else begin
      sck_d_ff <= sck_s;
      cs_d_ff  <= cs_b_s;
    end
  end

  assign sck_rise = sck_s && !sck_d_ff;
  assign sck_fall = !sck_s && sck_d_ff;
  assign cs_fall  = cs_d_ff && !cs_b_s;
  // Deselect or reset pin ends everything
  assign abort    = cs_b_s || !reset_b_s;

  // Address decode for both page sizes
  function automatic logic [17:0] split_addr(input logic [23:0] a, input logic p256);
    if (p256) begin
      split_addr = {a[16:8], 1'b0, a[7:0]};
    end else begin
      split_addr = {a[17:9], a[8:0]};
    end
  endfunction : split_addr

  function automatic logic [17:0] next_addr(input logic [17:0] pa, input logic p256,
                                            input logic cont);
    logic [8:0] last;
    last = p256 ? `SFR_LAST_OFFSET_256 : `SFR_LAST_OFFSET_264;
    if (pa[8:0] >= last) begin
      if (cont) begin
        // Last page rolls to page 0 by width
        next_addr = {9'(pa[17:9] + 9'h001), 9'h000};
      end else begin
        next_addr = {pa[17:9], 9'h000};
      end
    end else begin
      next_addr = {pa[17:9], 9'(pa[8:0] + 9'h001)};
    end
  endfunction : next_addr

  // Command phase tracking
  sfr_pkg::sfr_dev_phase_t phase_ff;
  logic [5:0]              bit_cnt_ff;
  logic [7:0]              op_ff;
  logic [22:0]             addr_ff;
  logic [5:0]              dummy_ff;
  logic                    cont_ff;
  logic                    load_ev;
  logic [7:0]              nxt_op;
  logic [23:0]             nxt_addr;

  assign nxt_op   = {op_ff[6:0], si_s};
  assign nxt_addr = {addr_ff, si_s};
  assign load_ev  = sck_rise && (phase_ff == sfr_pkg::SFR_PH_ADDR) &&
                    (bit_cnt_ff == `SFR_ADDR_BITS - 6'h01);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || abort) begin
      phase_ff   <= sfr_pkg::SFR_PH_IDLE;
      bit_cnt_ff <= '0;
      op_ff      <= '0;
      addr_ff    <= '0;
      dummy_ff   <= '0;
      cont_ff    <= 1'b0;
    end else begin
      unique case (phase_ff)
        sfr_pkg::SFR_PH_IDLE: begin
          if (cs_fall) begin
            phase_ff   <= sfr_pkg::SFR_PH_CMD;
            bit_cnt_ff <= '0;
          end
        end
        sfr_pkg::SFR_PH_CMD: begin
          // Leading fall in mode 3 is not counted
          if (sck_rise) begin
            op_ff      <= nxt_op;
            bit_cnt_ff <= 6'(bit_cnt_ff + 6'h01);
            if (bit_cnt_ff == `SFR_OPCODE_BITS - 6'h01) begin
              bit_cnt_ff <= '0;
              dummy_ff   <= sfr_pkg::sfr_dummy_bits(nxt_op);
              cont_ff    <= (nxt_op != `SFR_OP_PAGE_READ);
              phase_ff   <= sfr_pkg::sfr_is_read(nxt_op) ? sfr_pkg::SFR_PH_ADDR
                                                         : sfr_pkg::SFR_PH_IGNORE;
            end
          end
        end
        sfr_pkg::SFR_PH_ADDR: begin
          if (sck_rise) begin
            addr_ff    <= nxt_addr[22:0];
            bit_cnt_ff <= 6'(bit_cnt_ff + 6'h01);
            if (load_ev) begin
              bit_cnt_ff <= '0;
              phase_ff   <= (dummy_ff == 6'h00) ? sfr_pkg::SFR_PH_DATA
                                                : sfr_pkg::SFR_PH_DUMMY;
            end
          end
        end
        sfr_pkg::SFR_PH_DUMMY: begin
          if (sck_rise) begin
            bit_cnt_ff <= 6'(bit_cnt_ff + 6'h01);
            if (bit_cnt_ff == 6'(dummy_ff - 6'h01)) begin
              phase_ff <= sfr_pkg::SFR_PH_DATA;
            end
          end
        end
        sfr_pkg::SFR_PH_DATA,
        sfr_pkg::SFR_PH_IGNORE: begin
          // Held until deselect
        end
      endcase
    end
  end

  // Array fetch into the FIFO, one request in flight
  logic [17:0] fetch_pa_ff;
  logic        mem_rd_ff;
  logic        rd_q_ff;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        pop;
  logic        fetch_en;
  logic        busy_ff;

  assign fetch_en = (phase_ff == sfr_pkg::SFR_PH_DUMMY) || (phase_ff == sfr_pkg::SFR_PH_DATA);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || abort) begin
      mem_rd_ff   <= 1'b0;
      rd_q_ff     <= 1'b0;
      fetch_pa_ff <= '0;
    end else begin
      rd_q_ff   <= mem_rd_ff;
      mem_rd_ff <= fetch_en && !mem_rd_ff && !rd_q_ff && fifo_in_ready;
      if (load_ev) begin
        fetch_pa_ff <= split_addr(nxt_addr, page_256_i);
      end else if (mem_rd_ff) begin
        fetch_pa_ff <= next_addr(fetch_pa_ff, page_256_i, cont_ff);
      end
    end
  end

  // Read-only port: buffer contents never touched
  assign mem_rd_o     = mem_rd_ff;
  assign mem_page_o   = fetch_pa_ff[17:9];
  assign mem_offset_o = fetch_pa_ff[8:0];

  sfr_fifo #(
    .WIDTH(`SFR_FIFO_WIDTH),
    .DEPTH(`SFR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (abort),
    .in_valid_i  (rd_q_ff),
    .in_data_i   (mem_data_i),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (pop)
  );

  // Serializer drives on falling edges only
  logic       so_ff;
  logic       so_oe_ff;
  logic [6:0] tx_sh_ff;
  logic [2:0] tx_cnt_ff;

  assign pop = sck_fall && (phase_ff == sfr_pkg::SFR_PH_DATA) && (tx_cnt_ff == 3'h0) &&
               fifo_out_valid;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || abort) begin
      so_oe_ff  <= 1'b0;
      so_ff     <= 1'b0;
      tx_sh_ff  <= '0;
      tx_cnt_ff <= '0;
    end else if (sck_fall && (phase_ff == sfr_pkg::SFR_PH_DATA)) begin
      so_oe_ff <= 1'b1;
      if (tx_cnt_ff == 3'h0) begin
        // Underrun cannot occur at link rates; hold the line if it did
        if (fifo_out_valid) begin
          so_ff     <= fifo_out_data[7];
          tx_sh_ff  <= fifo_out_data[6:0];
          tx_cnt_ff <= 3'h1;
        end
      end else begin
        so_ff     <= tx_sh_ff[6];
        tx_sh_ff  <= {tx_sh_ff[5:0], 1'b0};
        tx_cnt_ff <= 3'(tx_cnt_ff + 3'h1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (phase_ff != sfr_pkg::SFR_PH_IDLE);
    end
  end

  assign link.so    = so_ff;
  assign link.so_oe = so_oe_ff;
  assign busy_o     = busy_ff;
endmodule : sfr_device
`default_nettype wire

// [rtl/sfr_host.sv]
// Purpose: Controller end of the serial link: issues one read command per request
// Assumes: Serial clock made here by dividing clk_i
// Notes:   Read data is not back-pressured; the user must take each byte
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"

module sfr_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Serial link
  sfr_link_if.host         link,
  // Command request
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_opcode_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [15:0] cmd_len_i,
  input  wire logic        mode3_i,
  input  wire logic        flash_reset_i,
  output logic             cmd_ready_o,
  // Read data
  output logic      [7:0]  rd_data_o,
  output logic             rd_valid_o,
  output logic             done_o
);
  localparam logic [7:0] HALF_BASE = 8'(`SFR_SCK_HALF_CYC);
  localparam logic [7:0] HALF_FAST = 8'(`SFR_FAST_HALF_MIN_CYC);
  localparam logic [7:0] HALF_SLOW = 8'(`SFR_SLOW_HALF_MIN_CYC);

  logic so_meta_ff;
  logic so_sync_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      so_meta_ff <= 1'b1;
      so_sync_ff <= 1'b1;
    end else begin
      so_meta_ff <= link.so_line;
      so_sync_ff <= so_meta_ff;
    end
  end

  sfr_pkg::sfr_host_state_t state_ff;
  logic        cs_b_ff;
  logic        sck_ff;
  logic        si_ff;
  logic        reset_b_ff;
  logic        ready_ff;
  logic        first_ff;
  logic        mode3_ff;
  logic [7:0]  half_ff;
  logic [7:0]  half_lim_ff;
  logic [31:0] tx_sh_ff;
  logic [19:0] bit_idx_ff;
  logic [19:0] total_ff;
  logic [19:0] hdr_ff;
  logic [7:0]  rx_sh_ff;
  logic [2:0]  rx_cnt_ff;
  logic [7:0]  rd_data_ff;
  logic        rd_valid_ff;
  logic        done_ff;
  logic        tick;
  logic [19:0] hdr_bits;
  logic [7:0]  nxt_half_lim;

  assign tick     = (half_ff == 8'(half_lim_ff - 8'h01));
  assign hdr_bits = 20'(`SFR_OPCODE_BITS) + 20'(`SFR_ADDR_BITS) +
                    20'(sfr_pkg::sfr_dummy_bits(cmd_opcode_i));
  // Slow read gets the lower clock ceiling
  assign nxt_half_lim = (cmd_opcode_i == `SFR_OP_SLOW_READ) ?
                        ((HALF_BASE > HALF_SLOW) ? HALF_BASE : HALF_SLOW) :
                        ((HALF_BASE > HALF_FAST) ? HALF_BASE : HALF_FAST);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reset_b_ff <= 1'b0;
    end else begin
      reset_b_ff <= !flash_reset_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || flash_reset_i) begin
      state_ff    <= sfr_pkg::SFR_HS_IDLE;
      cs_b_ff     <= 1'b1;
      sck_ff      <= 1'b0;
      si_ff       <= 1'b0;
      ready_ff    <= 1'b0;
      first_ff    <= 1'b0;
      mode3_ff    <= 1'b0;
      half_ff     <= '0;
      half_lim_ff <= HALF_BASE;
      tx_sh_ff    <= '0;
      bit_idx_ff  <= '0;
      total_ff    <= '0;
      hdr_ff      <= '0;
      rx_sh_ff    <= '0;
      rx_cnt_ff   <= '0;
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
      done_ff     <= 1'b0;
    end else begin
      rd_valid_ff <= 1'b0;
      done_ff     <= 1'b0;
      half_ff     <= tick ? 8'h00 : 8'(half_ff + 8'h01);
      unique case (state_ff)
        sfr_pkg::SFR_HS_IDLE: begin
          // One idle cycle after done keeps select high three cycles between frames
          ready_ff <= !done_ff;
          sck_ff   <= mode3_i;
          half_ff  <= '0;
          if (ready_ff && cmd_valid_i) begin
            ready_ff    <= 1'b0;
            cs_b_ff     <= 1'b0;
            si_ff       <= cmd_opcode_i[7];
            tx_sh_ff    <= {cmd_opcode_i, cmd_addr_i};
            mode3_ff    <= mode3_i;
            first_ff    <= mode3_i;
            half_lim_ff <= nxt_half_lim;
            hdr_ff      <= hdr_bits;
            total_ff    <= hdr_bits + 20'({1'b0, cmd_len_i, 3'b000});
            bit_idx_ff  <= '0;
            rx_cnt_ff   <= '0;
            state_ff    <= sfr_pkg::SFR_HS_SHIFT;
          end
        end
        sfr_pkg::SFR_HS_SHIFT: begin
          if (tick) begin
            if (!sck_ff) begin
              sck_ff <= 1'b1;
              // Sample on rising edge, data phase only
              if (bit_idx_ff >= hdr_ff) begin
                rx_sh_ff  <= {rx_sh_ff[6:0], so_sync_ff};
                rx_cnt_ff <= 3'(rx_cnt_ff + 3'h1);
                if (rx_cnt_ff == 3'h7) begin
                  rd_data_ff  <= {rx_sh_ff[6:0], so_sync_ff};
                  rd_valid_ff <= 1'b1;
                end
              end
              if (mode3_ff && (bit_idx_ff == 20'(total_ff - 20'h00001))) begin
                state_ff <= sfr_pkg::SFR_HS_DESEL;
              end
            end else begin
              sck_ff <= 1'b0;
              if (first_ff) begin
                first_ff <= 1'b0;
              end else begin
                bit_idx_ff <= 20'(bit_idx_ff + 20'h00001);
                tx_sh_ff   <= {tx_sh_ff[30:0], 1'b0};
                si_ff      <= tx_sh_ff[30];
                if (bit_idx_ff == 20'(total_ff - 20'h00001)) begin
                  state_ff <= sfr_pkg::SFR_HS_DESEL;
                end
              end
            end
          end
        end
        sfr_pkg::SFR_HS_DESEL: begin
          if (tick) begin
            cs_b_ff  <= 1'b1;
            si_ff    <= 1'b0;
            done_ff  <= 1'b1;
            state_ff <= sfr_pkg::SFR_HS_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cs_b    = cs_b_ff;
  assign link.sck     = sck_ff;
  assign link.si      = si_ff;
  assign link.reset_b = reset_b_ff;
  assign cmd_ready_o  = ready_ff;
  assign rd_data_o    = rd_data_ff;
  assign rd_valid_o   = rd_valid_ff;
  assign done_o       = done_ff;
endmodule : sfr_host
`default_nettype wire

// [verif/sfr_link_props.sv]
// Purpose: Link checker for the serial flash read path
// Assumes: Link signals sampled on clk_i
// Notes:   Counts raw sck rises per frame
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"
module sfr_link_props (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Link
  input  wire logic cs_b,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic so,
  input  wire logic so_oe,
  input  wire logic reset_b,
  input  wire logic so_line
);
  logic [6:0] rise_cnt_ff;
  logic [7:0] op_ff;
  logic       sck_q_ff;
  logic [6:0] want;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Mode 3 starts high, so a deselected sck never counts as a rise
  always_ff @(posedge clk_i) sck_q_ff <= sck || cs_b;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || cs_b) rise_cnt_ff <= 7'h00;
    else if (sck && !sck_q_ff) rise_cnt_ff <= rise_cnt_ff + 7'h01;
  end
  always_ff @(posedge clk_i) begin
    if (sck && !sck_q_ff && rise_cnt_ff < 7'h08) op_ff <= {op_ff[6:0], si};
  end
  always_comb begin
    case (op_ff)
      `SFR_OP_LEGACY_READ, `SFR_OP_PAGE_READ: want = 7'h40;
      `SFR_OP_FAST_READ: want = 7'h28;
      `SFR_OP_SLOW_READ: want = 7'h20;
      default: want = 7'h7F;
    endcase
  end
  property p_release; $rose(cs_b) |-> ##[1:4] !so_oe; endproperty
  a_release: assert property (p_release) else $error("output not released");
  property p_desel; cs_b [*6] |-> !so_oe; endproperty
  a_desel: assert property (p_desel) else $error("driving while deselected");
  property p_rst_pin; !reset_b [*5] |-> !so_oe; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("driving during pin reset");
  property p_so_hold; so_oe && $rose(sck) |-> $stable(so); endproperty
  a_so_hold: assert property (p_so_hold) else $error("so moved at rising sck");
  property p_si_hold; !cs_b && $rose(sck) |-> $stable(si); endproperty
  a_si_hold: assert property (p_si_hold) else $error("si moved at rising sck");
  property p_cs_gap; $rose(cs_b) |-> cs_b [*3]; endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
  property p_half; $changed(sck) |=> $stable(sck) [*5]; endproperty
  a_half: assert property (p_half) else $error("sck half period short");
  property p_data_start; $rose(so_oe) |-> rise_cnt_ff == want; endproperty
  a_data_start: assert property (p_data_start) else $error("data start wrong");
  property p_so_line; !so_oe |-> so_line; endproperty
  a_so_line: assert property (p_so_line) else $error("released line not high");
  c_data: cover property ($rose(so_oe));
  c_pin_rst: cover property ($fell(reset_b) && $rose(cs_b));
  c_mode3: cover property ($fell(cs_b) && sck);
endmodule : sfr_link_props
`default_nettype wire

// [verif/serial_flash_read_commands_test.sv]
// Purpose: Host and flash ends joined, read commands end to end
// Assumes: Array model answers one cycle after mem_rd
// Notes:   Bytes checked against a computed array pattern
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defs.svh"
module serial_flash_read_commands_test;
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [15:0] len;
    logic        p256;
    logic        m3;
  } sfr_row_t;
  logic        clk_i = 1'h0;
  logic        rst_b_i, page_256, mem_rd, busy, cmd_valid, mode3, flash_reset;
  logic        cmd_ready, rd_valid, done;
  logic [8:0]  mem_page, mem_offset;
  logic [7:0]  mem_data, cmd_op, rd_data;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_len;
  int          error_cnt, check_count;
  sfr_row_t    rows [8];
  sfr_link_if link_if ();
  sfr_device sfr_device_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if.device),
    .page_256_i(page_256), .mem_page_o(mem_page), .mem_offset_o(mem_offset),
    .mem_rd_o(mem_rd), .mem_data_i(mem_data), .busy_o(busy));
  sfr_host sfr_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if.host),
    .cmd_valid_i(cmd_valid), .cmd_opcode_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len),
    .mode3_i(mode3), .flash_reset_i(flash_reset), .cmd_ready_o(cmd_ready),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done));
  sfr_link_props sfr_link_props_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b(link_if.cs_b),
    .sck(link_if.sck), .si(link_if.si), .so(link_if.so), .so_oe(link_if.so_oe),
    .reset_b(link_if.reset_b), .so_line(link_if.so_line));
  always #2 clk_i = ~clk_i;
  function automatic logic [7:0] memf(input logic [8:0] p, input logic [8:0] o);
    return p[7:0] ^ o[7:0] ^ {p[8], 6'h00, o[8]};
  endfunction : memf
  always @(posedge clk_i) if (mem_rd) mem_data <= memf(mem_page, mem_offset);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic run_cmd(input sfr_row_t r);
    logic [8:0] pg;
    logic [8:0] of;
    logic       ok;
    int         n;
    int         t;
    ok = r.op inside {`SFR_OP_LEGACY_READ, `SFR_OP_FAST_READ,
                      `SFR_OP_SLOW_READ, `SFR_OP_PAGE_READ};
    pg = r.p256 ? r.addr[16:8] : r.addr[17:9];
    of = r.p256 ? {1'h0, r.addr[7:0]} : r.addr[8:0];
    {cmd_op, cmd_addr, cmd_len, page_256, mode3} = r;
    cmd_valid = 1'h1;
    t = 0;
    n = 0;
    do begin @(posedge clk_i); t++; end while (cmd_ready !== 1'h1 && t < 9000);
    #1 cmd_valid = 1'h0;
    while (done !== 1'h1 && t < 9000) begin
      @(posedge clk_i);
      t++;
      if (rd_valid === 1'h1) begin
        check(rd_data, ok ? memf(pg, of) : 8'hFF);
        n++;
        if (of != (r.p256 ? 9'h0FF : 9'h107)) of++;
        else begin
          of = 9'h000;
          if (r.op != `SFR_OP_PAGE_READ) pg++;
        end
      end
    end
    if (t >= 9000) error_cnt++;
    check(n[7:0], r.len[7:0]);
    #1;
  endtask : run_cmd
  initial begin
    rows[0] = '{8'hE8, 24'h00_0107, 16'h0003, 1'h0, 1'h0};
    rows[1] = '{8'h0B, 24'h01_FFFF, 16'h0003, 1'h1, 1'h1};
    rows[2] = '{8'h03, 24'hFE_3E05, 16'h0002, 1'h0, 1'h1};
    rows[3] = '{8'hD2, 24'h00_05FE, 16'h0003, 1'h1, 1'h0};
    rows[4] = '{8'hD2, 24'h00_0306, 16'h0003, 1'h0, 1'h1};
    rows[5] = '{8'hE8, 24'h03_FFFF, 16'h0002, 1'h1, 1'h0};
    rows[6] = '{8'h03, 24'h3F_FF07, 16'h0002, 1'h0, 1'h0};
    rows[7] = '{8'h52, 24'h00_0000, 16'h0002, 1'h0, 1'h0};
    {rst_b_i, cmd_valid, flash_reset} = '0;
    {cmd_op, cmd_addr, cmd_len, page_256, mode3} = rows[0];
    repeat (3) @(posedge clk_i);
    #1 check({4'h0, link_if.cs_b, link_if.so_oe, busy, cmd_ready}, 8'h08);
    rst_b_i = 1'h1;
    foreach (rows[i]) run_cmd(rows[i]);
    // Long read aborted by the reset pin in mid data phase
    {cmd_op, cmd_addr, cmd_len, page_256, mode3} = {rows[6].op, rows[6].addr, 16'h0028, 2'h0};
    cmd_valid = 1'h1;
    do @(posedge clk_i); while (cmd_ready !== 1'h1);
    #1 cmd_valid = 1'h0;
    // Mid data phase, well clear of the last sck edge
    repeat (1510) @(posedge clk_i);
    #1 flash_reset = 1'h1;
    repeat (6) @(posedge clk_i);
    #1 check({4'h0, link_if.cs_b, link_if.so_oe, busy, link_if.reset_b}, 8'h08);
    flash_reset = 1'h0;
    run_cmd(rows[3]);
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
endmodule : serial_flash_read_commands_test
`default_nettype wire
